// [design/cbpc_buffer_pair_ctrl.sv]
/*
 * control and status for one pair of can message buffers, with ahb-lite register
 * access, send arbitration toward the protocol engine and a level interrupt.
 * assumes the engine answers every started attempt with exactly one end event.
 */
// The register addresses and register access over AHB-Lite are this design's own decisions.
// Functional notes
// - one 16-bit register, odd high, even low
// - direction bit one transmits, zero receives
// - read-only aborted flag, clear on success
// - read-only flag set on lost arbitration
// - read-only flag set on bus error
// - writing send request one starts transmission
// - send request clears after successful send
// - writing zero to pending request aborts
// - remote request sets send request when enabled
// - setting send request clears all three flags
`timescale 1ns/1ns
module cbpc_buffer_pair_ctrl (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   input  wire cbpc_pkg::cbpc_eng_evt_t eng_evt,
   output logic                         tx_start,
   output logic                         tx_buf,
   output logic                         tx_abort,
   output logic                         irq
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   cbpc_pkg::cbpc_top_state_t s_r;
   cbpc_pkg::cbpc_top_state_t s_nxt;
   cbpc_pkg::cbpc_ctl_byte_t  ctl [cbpc_pkg::NUM_BUF];
   cbpc_pkg::cbpc_irq_nib_t   ie  [cbpc_pkg::NUM_BUF];
   logic [cbpc_pkg::NUM_BUF-1:0] act;
   logic [cbpc_pkg::NUM_BUF-1:0] pend;
   logic [cbpc_pkg::NUM_BUF-1:0] wr_en;
   logic [cbpc_pkg::NUM_BUF-1:0] elig;
   logic [cbpc_pkg::NUM_BUF-1:0] ev_ok;
   logic [cbpc_pkg::NUM_BUF-1:0] ev_abd;
   logic [cbpc_pkg::NUM_BUF-1:0] ev_arb;
   logic [cbpc_pkg::NUM_BUF-1:0] ev_err;
   logic [cbpc_pkg::NUM_BUF-1:0] ev_rtr;
   logic                         rd_take;
   logic                         wr_phase;
   logic [31:0]                  wr_addr;
   logic                         sel;
   logic                         end_evt;
   logic [15:0]                  ctrl_word;
   logic [7:0]                   ie_bits;

   // ----------------------------------------
   // bus capture
   // ----------------------------------------
   // hsize is not checked: only whole-word transfers reach this slave
   cbpc_ahb_cap u_cap (
      .clk      (clk),
      .reset_n  (reset_n),
      .hsel     (hsel),
      .htrans   (htrans),
      .haddr    (haddr),
      .hwrite   (hwrite),
      .hready   (hready),
      .rd_take  (rd_take),
      .wr_phase (wr_phase),
      .wr_addr  (wr_addr)
   );

   // ----------------------------------------
   // buffer bytes
   // ----------------------------------------
   assign end_evt = eng_evt.ok || eng_evt.abort_done || eng_evt.arb_lost || eng_evt.bus_err;

   for (genvar b = 0; b < cbpc_pkg::NUM_BUF; b++) begin : g_buf
      assign act[b]    = (s_r.state == cbpc_pkg::CBPC_SEND) && (s_r.tx_buf == 1'(b));
      assign wr_en[b]  = wr_phase && (wr_addr == cbpc_pkg::OFS_CTRL);
      assign ev_ok[b]  = act[b] && eng_evt.ok;
      assign ev_abd[b] = act[b] && eng_evt.abort_done;
      assign ev_arb[b] = act[b] && eng_evt.arb_lost;
      assign ev_err[b] = act[b] && eng_evt.bus_err;
      assign ev_rtr[b] = eng_evt.rtr_rx && (eng_evt.idx == 1'(b));
      assign elig[b]   = ctl[b].req && ctl[b].dir && !pend[b];
      assign ie_bits[b*cbpc_pkg::NIB_W +: cbpc_pkg::NIB_W] = ie[b];

      cbpc_buf_byte u_buf (
         .clk           (clk),
         .reset_n       (reset_n),
         .wr_en         (wr_en[b]),
         .wr_byte       (cbpc_pkg::cbpc_ctl_byte_t'(hwdata[b*cbpc_pkg::BYTE_W +: cbpc_pkg::BYTE_W])),
         .active        (act[b]),
         .ev_ok         (ev_ok[b]),
         .ev_abort_done (ev_abd[b]),
         .ev_arb_lost   (ev_arb[b]),
         .ev_bus_err    (ev_err[b]),
         .ev_rtr        (ev_rtr[b]),
         .ctl           (ctl[b]),
         .abort_pend    (pend[b]),
         .irq_ev        (ie[b])
      );
   end

   assign ctrl_word = {ctl[1], ctl[0]};

   // ties go to the even buffer
   assign sel = elig[1] && (!elig[0] || (ctl[1].pri > ctl[0].pri));

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_nxt          = s_r;
      s_nxt.tx_start = 1'h0;
      s_nxt.hready   = 1'h1;
      unique case (s_r.state)
         cbpc_pkg::CBPC_IDLE: begin
            if (|elig) begin
               s_nxt.tx_start = 1'h1;
               s_nxt.tx_buf   = sel;
               s_nxt.state    = cbpc_pkg::CBPC_SEND;
            end
         end
         cbpc_pkg::CBPC_SEND: begin
            // request stays set after loss or error, so idle re-arbitrates
            if (end_evt) begin
               s_nxt.state = cbpc_pkg::CBPC_IDLE;
            end
         end
         default: begin
            s_nxt.state = cbpc_pkg::CBPC_IDLE;
         end
      endcase
      s_nxt.tx_abort = (s_nxt.state == cbpc_pkg::CBPC_SEND) && pend[s_nxt.tx_buf];
      // read clears status, a same-cycle event still lands
      if (rd_take && (haddr == cbpc_pkg::OFS_STATUS)) begin
         s_nxt.status = cbpc_pkg::IRQ_RST;
      end
      s_nxt.status = s_nxt.status | ie_bits;
      if (wr_phase && (wr_addr == cbpc_pkg::OFS_MASK)) begin
         s_nxt.mask = hwdata[7:0];
      end
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);
      if (rd_take) begin
         unique case (haddr)
            cbpc_pkg::OFS_CTRL:   s_nxt.hrdata = {16'h0000, ctrl_word};
            cbpc_pkg::OFS_STATUS: s_nxt.hrdata = {24'h00_0000, s_r.status};
            cbpc_pkg::OFS_MASK:   s_nxt.hrdata = {24'h00_0000, s_r.mask};
            default:              s_nxt.hrdata = cbpc_pkg::RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '{state:    cbpc_pkg::CBPC_IDLE,
                  tx_start: 1'h0,
                  tx_buf:   1'h0,
                  tx_abort: 1'h0,
                  status:   cbpc_pkg::IRQ_RST,
                  mask:     cbpc_pkg::IRQ_RST,
                  irq:      1'h0,
                  hrdata:   cbpc_pkg::RDATA_RST,
                  hready:   1'h1};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hreadyout = s_r.hready;
   assign hresp     = cbpc_pkg::HRESP_OKAY;
   assign hrdata    = s_r.hrdata;
   assign tx_start  = s_r.tx_start;
   assign tx_buf    = s_r.tx_buf;
   assign tx_abort  = s_r.tx_abort;
   assign irq       = s_r.irq;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_ctrl_readback: assert property (
      rd_take && (haddr == cbpc_pkg::OFS_CTRL) |=> hrdata == {16'h0000, $past(ctrl_word)})
      else $error("control word read back wrong");

   a_rx_no_start: assert property (
      (s_r.state == cbpc_pkg::CBPC_IDLE) && !ctl[0].dir && !ctl[1].dir |=> !tx_start)
      else $error("receive buffer started a send");

   a_abort_idle: assert property (
      wr_en[0] && !hwdata[3] && ctl[0].req && !act[0] && !ev_rtr[0]
      |=> !ctl[0].req && ctl[0].abt && s_r.status[2])
      else $error("idle abort not taken");

   a_abort_busy: assert property (
      wr_en[0] && !hwdata[3] && ctl[0].req && act[0] && !end_evt
      |=> pend[0] && ctl[0].req)
      else $error("busy abort not held pending");

   a_ok_clears: assert property (
      ev_ok[0] |=> !ctl[0].req && !ctl[0].abt ##1 !tx_start || tx_buf)
      else $error("send request kept after success");

   a_arb_flag: assert property (
      ev_arb[0] && !wr_en[0] |=> ctl[0].larb && (ctl[0].req || pend[0] == 1'h0))
      else $error("arbitration loss not flagged");

   a_err_retry: assert property (
      ev_err[0] && !wr_en[0] && !pend[0] && ctl[0].dir |=> ctl[0].err && ctl[0].req
      ##1 tx_start)
      else $error("bus error not flagged or not retried");

   a_start_req: assert property (
      (s_r.state == cbpc_pkg::CBPC_IDLE) && (|elig)
      |=> tx_start && (s_r.state == cbpc_pkg::CBPC_SEND) ##1 !tx_start)
      else $error("pending request not started");

   a_flags_clear: assert property (
      wr_en[0] && hwdata[3] && !ev_arb[0] && !ev_err[0] && !ev_abd[0] && !ev_ok[0]
      |=> !ctl[0].abt && !ctl[0].larb && !ctl[0].err && ctl[0].req)
      else $error("flags not cleared by new request");

   a_rtr_reply: assert property (
      ev_rtr[0] && ctl[0].rtren && !wr_en[0] && !act[0] |=> ctl[0].req)
      else $error("remote request not answered");

   a_rtr_ignored: assert property (
      ev_rtr[1] && !ctl[1].rtren && !ctl[1].req && !wr_en[1] |=> !ctl[1].req)
      else $error("remote request set a disabled buffer");

   a_pri_write: assert property (
      wr_en[1] |=> ctl[1].pri == $past(hwdata[9:8]))
      else $error("priority field not written");

   a_pri_odd_wins: assert property (
      (s_r.state == cbpc_pkg::CBPC_IDLE) && (&elig) && (ctl[1].pri > ctl[0].pri)
      |=> tx_start && tx_buf)
      else $error("higher odd priority lost");

   a_pri_even_wins: assert property (
      (s_r.state == cbpc_pkg::CBPC_IDLE) && (&elig) && (ctl[0].pri >= ctl[1].pri)
      |=> tx_start && !tx_buf)
      else $error("even buffer lost on equal or higher priority");

   a_status_sticky: assert property (
      s_r.status[0] && !(rd_take && (haddr == cbpc_pkg::OFS_STATUS)) |=> s_r.status[0])
      else $error("status bit dropped without a read");

   c_send_ok:  cover property (tx_start ##[1:20] eng_evt.ok);
   c_retry:    cover property (ev_arb[0] ##[1:4] tx_start);
   c_abort:    cover property (tx_abort ##[1:20] eng_evt.abort_done);
   c_rtr:      cover property (ev_rtr[0] && ctl[0].rtren ##1 ctl[0].req);

endmodule : cbpc_buffer_pair_ctrl

// [shared/cbpc_pkg.sv]
/*
 * shared constants, carriers and state types for the can buffer pair control block.
 * assumes one 32-bit ahb-lite slave port and a protocol engine on the far side.
 */
package cbpc_pkg;

   // ----------------------------------------
   // sizes and register map
   // ----------------------------------------
   localparam int unsigned NUM_BUF       = 2;
   localparam int unsigned BYTE_W        = 8;
   localparam int unsigned NIB_W         = 4;
   localparam logic [31:0] OFS_CTRL      = 32'h0000_0000;
   localparam logic [31:0] OFS_STATUS    = 32'h0000_0004;
   localparam logic [31:0] OFS_MASK      = 32'h0000_0008;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'h0;
   localparam logic [7:0]  CTL_BYTE_RST  = 8'h00;
   localparam logic [7:0]  IRQ_RST       = 8'h00;
   localparam logic [31:0] RDATA_RST     = 32'h0000_0000;
   localparam logic [31:0] ADDR_RST      = 32'h0000_0000;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic       dir;
      logic       abt;
      logic       larb;
      logic       err;
      logic       req;
      logic       rtren;
      logic [1:0] pri;
   } cbpc_ctl_byte_t;

   typedef struct packed {
      logic ok;
      logic abt;
      logic larb;
      logic err;
   } cbpc_irq_nib_t;

   typedef struct packed {
      logic ok;
      logic abort_done;
      logic arb_lost;
      logic bus_err;
      logic rtr_rx;
      logic idx;
   } cbpc_eng_evt_t;

   typedef enum logic [1:0] {
      CBPC_IDLE = 2'h1,
      CBPC_SEND = 2'h2
   } cbpc_state_t;

   // ----------------------------------------
   // module state
   // ----------------------------------------
   typedef struct packed {
      cbpc_ctl_byte_t ctl;
      logic           pend;
   } cbpc_buf_state_t;

   typedef struct packed {
      logic        pend;
      logic [31:0] addr;
   } cbpc_cap_state_t;

   typedef struct packed {
      cbpc_state_t state;
      logic        tx_start;
      logic        tx_buf;
      logic        tx_abort;
      logic [7:0]  status;
      logic [7:0]  mask;
      logic        irq;
      logic [31:0] hrdata;
      logic        hready;
   } cbpc_top_state_t;

endpackage : cbpc_pkg

// [design/cbpc_ahb_cap.sv]
/*
 * ahb-lite address phase capture: flags a write data phase and keeps its address.
 * assumes single transfers only, so a data phase is never overlapped by a new address.
 */
`timescale 1ns/1ns
module cbpc_ahb_cap (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [1:0]  htrans,
   input  wire logic [31:0] haddr,
   input  wire logic        hwrite,
   input  wire logic        hready,
   output logic             rd_take,
   output logic             wr_phase,
   output logic [31:0]      wr_addr
);
   cbpc_pkg::cbpc_cap_state_t s_r;
   cbpc_pkg::cbpc_cap_state_t s_nxt;
   logic                      take;

   always_comb begin
      take  = hsel && hready && (htrans == cbpc_pkg::HTRANS_NONSEQ);
      s_nxt = s_r;
      s_nxt.pend = take && hwrite;
      if (take) begin
         s_nxt.addr = haddr;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '{pend: 1'h0, addr: cbpc_pkg::ADDR_RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_take  = take && !hwrite;
   assign wr_phase = s_r.pend;
   assign wr_addr  = s_r.addr;

endmodule : cbpc_ahb_cap

// [design/cbpc_buf_byte.sv]
/*
 * control byte of one message buffer: direction, flags, send request, priority.
 * assumes engine events arrive already gated to this buffer and to its active send.
 */
`timescale 1ns/1ns
module cbpc_buf_byte (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic                      wr_en,
   input  wire cbpc_pkg::cbpc_ctl_byte_t  wr_byte,
   input  wire logic                      active,
   input  wire logic                      ev_ok,
   input  wire logic                      ev_abort_done,
   input  wire logic                      ev_arb_lost,
   input  wire logic                      ev_bus_err,
   input  wire logic                      ev_rtr,
   output cbpc_pkg::cbpc_ctl_byte_t       ctl,
   output logic                           abort_pend,
   output cbpc_pkg::cbpc_irq_nib_t        irq_ev
);
   cbpc_pkg::cbpc_buf_state_t s_r;
   cbpc_pkg::cbpc_buf_state_t s_nxt;

   always_comb begin
      s_nxt  = s_r;
      irq_ev = '0;
      // pending abort of an attempt that has ended
      if (s_r.pend && !active) begin
         s_nxt.ctl.req = 1'h0;
         s_nxt.ctl.abt = 1'h1;
         s_nxt.pend    = 1'h0;
         irq_ev.abt    = 1'h1;
      end
      if (wr_en) begin
         s_nxt.ctl.dir   = wr_byte.dir;
         s_nxt.ctl.rtren = wr_byte.rtren;
         s_nxt.ctl.pri   = wr_byte.pri;
         if (wr_byte.req) begin
            s_nxt.ctl.req  = 1'h1;
            s_nxt.ctl.abt  = 1'h0;
            s_nxt.ctl.larb = 1'h0;
            s_nxt.ctl.err  = 1'h0;
            s_nxt.pend     = 1'h0;
         end else if (s_r.ctl.req) begin
            // abort of a frame on the wire must wait for the engine
            if (active) begin
               s_nxt.pend = 1'h1;
            end else begin
               s_nxt.ctl.req = 1'h0;
               s_nxt.ctl.abt = 1'h1;
               irq_ev.abt    = 1'h1;
            end
         end
      end
      if (ev_rtr && s_r.ctl.rtren && !s_nxt.ctl.req) begin
         s_nxt.ctl.req  = 1'h1;
         s_nxt.ctl.abt  = 1'h0;
         s_nxt.ctl.larb = 1'h0;
         s_nxt.ctl.err  = 1'h0;
      end
      // engine events last so that they win over software
      if (ev_ok) begin
         s_nxt.ctl.req = 1'h0;
         s_nxt.ctl.abt = 1'h0;
         s_nxt.pend    = 1'h0;
         irq_ev.ok     = 1'h1;
      end
      if (ev_abort_done) begin
         s_nxt.ctl.req = 1'h0;
         s_nxt.ctl.abt = 1'h1;
         s_nxt.pend    = 1'h0;
         irq_ev.abt    = 1'h1;
      end
      if (ev_arb_lost) begin
         s_nxt.ctl.larb = 1'h1;
         irq_ev.larb    = 1'h1;
      end
      if (ev_bus_err) begin
         s_nxt.ctl.err = 1'h1;
         irq_ev.err    = 1'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '{ctl: cbpc_pkg::CTL_BYTE_RST, pend: 1'h0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ctl        = s_r.ctl;
   assign abort_pend = s_r.pend;

endmodule : cbpc_buf_byte

// [tb/cbpc_engine_model.sv]
/*
 * behavioural protocol engine facing the buffer pair control block.
 * assumes the bench picks the outcome and latency of each attempt and the remote frames.
 */
`timescale 1ns/1ns
module cbpc_engine_model (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               tx_start,
   input  wire logic               tx_abort,
   input  wire logic [1:0]         res_kind,
   input  wire logic [7:0]         delay,
   input  wire logic               rtr_req,
   input  wire logic               rtr_sel,
   output cbpc_pkg::cbpc_eng_evt_t eng_evt
);
   // ----------------------------------------
   // one end event for every started attempt
   // ----------------------------------------
   logic       busy;
   logic [7:0] cnt;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy    <= 1'b0;
         cnt     <= 8'h00;
         eng_evt <= '0;
      end else begin
         eng_evt     <= '0;
         // idx toggles when unqualified so a stale index never looks valid
         eng_evt.idx <= ~eng_evt.idx;
         if (rtr_req) begin
            eng_evt.rtr_rx <= 1'b1;
            eng_evt.idx    <= rtr_sel;
         end
         if (tx_start) begin
            busy <= 1'b1;
            cnt  <= delay;
         end else if (busy && tx_abort) begin
            busy               <= 1'b0;
            eng_evt.abort_done <= 1'b1;
         end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            case (res_kind)
               2'h0:    eng_evt.ok       <= 1'b1;
               2'h1:    eng_evt.arb_lost <= 1'b1;
               default: eng_evt.bus_err  <= 1'b1;
            endcase
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule : cbpc_engine_model

// [tb/cbpc_buffer_pair_ctrl_tb_top.sv]
/*
 * self-checking bench for the buffer pair control block, register access over ahb-lite.
 * assumes one slave, zero-wait answers awaited anyway, and the engine model beside it.
 */
`timescale 1ns/1ns
module cbpc_buffer_pair_ctrl_tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic                    clk;
   logic                    reset_n;
   logic                    hsel;
   logic [31:0]             haddr;
   logic [1:0]              htrans;
   logic                    hwrite;
   logic [2:0]              hsize;
   logic [31:0]             hwdata;
   logic                    hreadyout;
   logic                    hresp;
   logic [31:0]             hrdata;
   cbpc_pkg::cbpc_eng_evt_t eng_evt;
   logic                    tx_start;
   logic                    tx_buf;
   logic                    tx_abort;
   logic                    irq;
   logic [1:0]              eng_kind;
   logic [7:0]              eng_delay;
   logic                    rtr_req;
   logic                    rtr_sel;
   logic [31:0]             rd;
   int                      n_errors;
   int                      check_count;
   int                      n_starts;
   int                      n0;
   logic                    saw_abort;
   logic                    start_q[$];

   cbpc_buffer_pair_ctrl dut_u (
      .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .eng_evt(eng_evt),
      .tx_start(tx_start), .tx_buf(tx_buf), .tx_abort(tx_abort), .irq(irq));

   cbpc_engine_model eng_u (
      .clk(clk), .reset_n(reset_n), .tx_start(tx_start), .tx_abort(tx_abort),
      .res_kind(eng_kind), .delay(eng_delay), .rtr_req(rtr_req), .rtr_sel(rtr_sel),
      .eng_evt(eng_evt));

   // ----------------------------------------
   // clock, monitor, watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (tx_start === 1'b1) begin
         n_starts <= n_starts + 1;
         start_q.push_back(tx_buf);
      end
      if (tx_abort === 1'b1) saw_abort <= 1'b1;
   end

   // whole run is a few hundred cycles; this is far beyond it
   initial begin
      #(40 * 40000);
      n_errors++;
      finish_test();
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // called right after a rising edge; holds each phase until hready is seen high
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
      htrans <= cbpc_pkg::HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rdr(input logic [31:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0000_0000, q);
   endtask : rdr

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wait_starts(input int n);
      int i;
      i = 0;
      while (n_starts < n && i < 2000) begin
         @(posedge clk);
         i++;
      end
      chk(32'(n_starts >= n), 32'h1);
   endtask : wait_starts

   task automatic test_end(input string name);
      $display("test %s done, errors so far %0d", name, n_errors);
   endtask : test_end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      reset_n = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; eng_kind = 2'h0; eng_delay = 8'h04;
      rtr_req = 1'b0; rtr_sel = 1'b0; n_errors = 0; check_count = 0;
      n_starts = 0; saw_abort = 1'b0;
      cyc(4);
      reset_n <= 1'b1;
      @(posedge clk);
      // reset values and an unmapped word
      rdr(cbpc_pkg::OFS_CTRL, rd); chk(rd, 32'h0);
      rdr(cbpc_pkg::OFS_STATUS, rd); chk(rd, 32'h0);
      rdr(cbpc_pkg::OFS_MASK, rd); chk(rd, 32'h0);
      wr(32'h0000_000c, 32'hffff_ffff);
      rdr(32'h0000_000c, rd); chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      test_end("reset");
      // both buffers pending, odd has higher priority; read-only bits written high
      wr(cbpc_pkg::OFS_MASK, 32'h0000_00ff);
      wr(cbpc_pkg::OFS_CTRL, 32'h0000_8bf9);
      wait_starts(2);
      cyc(10);
      chk({31'h0, start_q[0]}, 32'h1);
      chk({31'h0, start_q[1]}, 32'h0);
      rdr(cbpc_pkg::OFS_CTRL, rd); chk(rd, 32'h0000_8381);
      chk({31'h0, irq}, 32'h1);
      rdr(cbpc_pkg::OFS_STATUS, rd); chk(rd, 32'h0000_0088);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      test_end("priority");
      // lost arbitration, then bus error: flag set, request kept, retried
      eng_delay <= 8'h02;
      for (int k = 1; k <= 2; k++) begin
         eng_kind <= 2'(k);
         n0 = n_starts;
         wr(cbpc_pkg::OFS_CTRL, 32'h0000_0088);
         wait_starts(n0 + 2);
         rdr(cbpc_pkg::OFS_CTRL, rd);
         chk(rd, (k == 1) ? 32'h0000_00a8 : 32'h0000_0098);
         eng_kind <= 2'h0;
         cyc(10);
         rdr(cbpc_pkg::OFS_CTRL, rd); chk({31'h0, rd[3]}, 32'h0);
         rdr(cbpc_pkg::OFS_STATUS, rd);
         chk(rd, (k == 1) ? 32'h0000_000a : 32'h0000_0009);
      end
      test_end("retry");
      // abort in mid-send, then set again and see the flags go
      eng_delay <= 8'h3c;
      n0 = n_starts;
      wr(cbpc_pkg::OFS_CTRL, 32'h0000_0088);
      wait_starts(n0 + 1);
      wr(cbpc_pkg::OFS_CTRL, 32'h0000_0080);
      cyc(10);
      chk({31'h0, saw_abort}, 32'h1);
      rdr(cbpc_pkg::OFS_CTRL, rd); chk(rd, 32'h0000_00c0);
      rdr(cbpc_pkg::OFS_STATUS, rd); chk(rd, 32'h0000_0004);
      eng_delay <= 8'h02;
      wr(cbpc_pkg::OFS_CTRL, 32'h0000_0088);
      rdr(cbpc_pkg::OFS_CTRL, rd); chk(rd & 32'h0000_0070, 32'h0);
      cyc(10);
      rdr(cbpc_pkg::OFS_STATUS, rd); chk(rd, 32'h0000_0008);
      test_end("abort");
      // remote frames: even enabled, odd not; receive buffers are never sent
      n0 = n_starts;
      wr(cbpc_pkg::OFS_CTRL, 32'h0000_0004);
      rtr_req <= 1'b1;
      rtr_sel <= 1'b0;
      @(posedge clk);
      rtr_sel <= 1'b1;
      @(posedge clk);
      rtr_req <= 1'b0;
      cyc(6);
      rdr(cbpc_pkg::OFS_CTRL, rd); chk(rd, 32'h0000_000c);
      chk(32'(n_starts), 32'(n0));
      // abort of a request that is pending but not on the wire
      wr(cbpc_pkg::OFS_CTRL, 32'h0000_0004);
      rdr(cbpc_pkg::OFS_CTRL, rd); chk(rd, 32'h0000_0044);
      rdr(cbpc_pkg::OFS_STATUS, rd); chk(rd, 32'h0000_0004);
      wr(cbpc_pkg::OFS_CTRL, 32'h0000_008c);
      wait_starts(n0 + 1);
      cyc(10);
      rdr(cbpc_pkg::OFS_CTRL, rd); chk(rd, 32'h0000_0084);
      rdr(cbpc_pkg::OFS_STATUS, rd); chk(rd, 32'h0000_0008);
      test_end("remote");
      // masked event keeps irq low until unmasked
      wr(cbpc_pkg::OFS_MASK, 32'h0000_0000);
      wr(cbpc_pkg::OFS_CTRL, 32'h0000_0088);
      cyc(12);
      chk({31'h0, irq}, 32'h0);
      wr(cbpc_pkg::OFS_MASK, 32'h0000_0008);
      cyc(2);
      chk({31'h0, irq}, 32'h1);
      rdr(cbpc_pkg::OFS_MASK, rd); chk(rd, 32'h0000_0008);
      rdr(cbpc_pkg::OFS_STATUS, rd); chk(rd, 32'h0000_0008);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      test_end("irq");
      finish_test();
   end
endmodule : cbpc_buffer_pair_ctrl_tb_top
